// ===== verilog/gain_port_pkg.sv
// Shared constants and types for the pre-amplifier gain serial port.
// Assumes both ends and the bench import this package.
package gain_port_pkg;

	// ----------------------------------------------------------------
	// Word layout
	// ----------------------------------------------------------------
	localparam int unsigned WORD_BITS  = 8;
	localparam int unsigned CODE_BITS  = 4;
	localparam int unsigned CHB_MSB    = 7;
	localparam int unsigned CHB_LSB    = 4;
	localparam int unsigned CHA_MSB    = 3;
	localparam int unsigned CHA_LSB    = 0;
	localparam logic [7:0]  WORD_RESET = 8'h00;
	localparam logic [2:0]  LAST_BIT   = 3'h7;
	// Converted samples: two's complement, full scale of the input range
	localparam int unsigned SAMPLE_BITS = 14;
	localparam int unsigned FULL_SCALE  = 8192;

	// ----------------------------------------------------------------
	// Gain codes
	// ----------------------------------------------------------------
	localparam logic [3:0] CODE_ZERO = 4'h0;
	localparam logic [3:0] CODE_M1   = 4'h1;
	localparam logic [3:0] CODE_M2   = 4'h2;
	localparam logic [3:0] CODE_M5   = 4'h3;
	localparam logic [3:0] CODE_M10  = 4'h4;
	localparam logic [3:0] CODE_M20  = 4'h5;
	localparam logic [3:0] CODE_M50  = 4'h6;
	localparam logic [3:0] CODE_M100 = 4'h7;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ       = 50_000_000;
	localparam int unsigned LINK_MAX_HZ  = 10_000_000;
	// Half period of the link clock in system cycles, rounded up so the rate stays at or below max
	localparam int unsigned HALF_CYCLES  = (CLK_HZ + 2 * LINK_MAX_HZ - 1) / (2 * LINK_MAX_HZ);
	localparam logic [3:0]  HALF_LAST    = 4'(HALF_CYCLES - 1);

	typedef logic signed [7:0] gain_t;

	function automatic gain_t gain_of(input logic [3:0] code);
		unique case (code)
			CODE_ZERO: gain_of = 8'sh00;
			CODE_M1:   gain_of = -8'sd1;
			CODE_M2:   gain_of = -8'sd2;
			CODE_M5:   gain_of = -8'sd5;
			CODE_M10:  gain_of = -8'sd10;
			CODE_M20:  gain_of = -8'sd20;
			CODE_M50:  gain_of = -8'sd50;
			CODE_M100: gain_of = -8'sd100;
			default:   gain_of = 8'sh00;
		endcase
	endfunction

endpackage

// ===== verilog/gain_link_if.sv
// Serial link between the gain-port master and the pre-amplifier.
// Assumes the bench connects both modports; no clocking block.
`timescale 1ns/1ps
`default_nettype none
interface gain_link_if;
	logic serial_clock;
	logic master_data;
	logic gain_port_select_n;
	logic gain_echo_out;
	logic preamp_shutdown;
	logic other_select_n;
	logic converter_start;

	modport master (
		output serial_clock,
		output master_data,
		output gain_port_select_n,
		input  gain_echo_out,
		output preamp_shutdown,
		output other_select_n,
		output converter_start
	);

	modport amp (
		input  serial_clock,
		input  master_data,
		input  gain_port_select_n,
		output gain_echo_out,
		input  preamp_shutdown
	);
endinterface
`default_nettype wire

// ===== verilog/gain_master.sv
// Master end: serialises one gain word per request onto the link.
// Assumes a 50 MHz system clock; link clock derived here by a divider.
// Also parks the shared link's neighbour selects at their idle levels.
`timescale 1ns/1ps
`default_nettype none
module gain_master
	import gain_port_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       en_i,
	input  wire logic       start_i,
	input  wire logic [3:0] channel_a_gain_code_i,
	input  wire logic [3:0] channel_b_gain_code_i,
	input  wire logic       shutdown_i,
	output logic            busy_o,
	output logic            done_o,
	output logic [7:0]      echo_word_o,
	gain_link_if.master     link
);

	typedef enum logic [2:0] {IDLE, SETUP, LOW, HIGH, FINISH} state_e;

	typedef struct packed {
		state_e     state;
		logic [3:0] div;
		logic [2:0] bit_idx;
		logic [7:0] tx;
		logic [7:0] rx;
		logic [7:0] echo;
		logic       sck;
		logic       sel_n;
		logic       busy;
		logic       done;
		logic       shdn;
		logic       echo_s1;
		logic       echo_s2;
		logic       other_sel_n;
		logic       conv_start;
	} state_s;

	// Idle link: select high, clock low, neighbours parked
	localparam state_s CUR_RESET = '{
		state:       IDLE,
		div:         4'h0,
		bit_idx:     3'h0,
		tx:          WORD_RESET,
		rx:          WORD_RESET,
		echo:        WORD_RESET,
		sck:         1'b0,
		sel_n:       1'b1,
		busy:        1'b0,
		done:        1'b0,
		shdn:        1'b0,
		echo_s1:     1'b0,
		echo_s2:     1'b0,
		other_sel_n: 1'b1,
		conv_start:  1'b0
	};

	state_s cur_q, nxt_d;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// One half period of the link clock has elapsed
	function automatic logic half_elapsed(input logic [3:0] div);
		return div == HALF_LAST;
	endfunction

	// Move a word one place towards its top bit, filling the bottom bit
	function automatic logic [7:0] shift_in(input logic [7:0] word, input logic fill);
		return {word[6:0], fill};
	endfunction

	// Channel B field leads the word so it goes out first
	function automatic logic [7:0] word_of(input logic [3:0] code_b, input logic [3:0] code_a);
		return {code_b, code_a};
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		nxt_d             = cur_q;

		// --------------------------------------------------------
		// Pulses, synchronisers and parked neighbours
		// --------------------------------------------------------
		nxt_d.done        = 1'b0;
		nxt_d.shdn        = shutdown_i;
		nxt_d.echo_s1     = link.gain_echo_out;
		nxt_d.echo_s2     = cur_q.echo_s1;
		// Neighbours kept at their disabling levels, between frames too
		nxt_d.other_sel_n = 1'b1;
		nxt_d.conv_start  = 1'b0;
		if (cur_q.state != IDLE) begin
			nxt_d.div = cur_q.div + 4'h1;
		end

		// --------------------------------------------------------
		// Frame sequencing
		// --------------------------------------------------------
		unique case (cur_q.state)
			IDLE: begin
				nxt_d.div = 4'h0;
				// Only looked at here, so a start while busy is dropped
				if (start_i) begin
					nxt_d.tx      = word_of(channel_b_gain_code_i,
						channel_a_gain_code_i);
					nxt_d.sel_n   = 1'b0;
					nxt_d.busy    = 1'b1;
					nxt_d.bit_idx = 3'h0;
					nxt_d.state   = SETUP;
				end
			end

			SETUP: begin
				// Select settles a half period before the first rising edge
				if (half_elapsed(cur_q.div)) begin
					nxt_d.div   = 4'h0;
					nxt_d.sck   = 1'b1;
					nxt_d.state = HIGH;
				end
			end

			HIGH: begin
				if (half_elapsed(cur_q.div)) begin
					nxt_d.div   = 4'h0;
					nxt_d.sck   = 1'b0;
					// Echo last moved on the previous falling edge; synchroniser settled
					nxt_d.rx    = shift_in(cur_q.rx, cur_q.echo_s2);
					if (cur_q.bit_idx == LAST_BIT) begin
						// Last bit stays on the wire until select rises; no ninth edge
						nxt_d.state = FINISH;
					end else begin
						// Next bit launched with the fall, half a period before the rise
						nxt_d.tx      = shift_in(cur_q.tx, 1'b0);
						nxt_d.bit_idx = cur_q.bit_idx + 3'h1;
						nxt_d.state   = LOW;
					end
				end
			end

			LOW: begin
				if (half_elapsed(cur_q.div)) begin
					nxt_d.div   = 4'h0;
					nxt_d.sck   = 1'b1;
					nxt_d.state = HIGH;
				end
			end

			FINISH: begin
				// Clock stays low for a half period before select rises
				if (half_elapsed(cur_q.div)) begin
					nxt_d.sel_n = 1'b1;
					nxt_d.busy  = 1'b0;
					nxt_d.done  = 1'b1;
					nxt_d.echo  = cur_q.rx;
					nxt_d.state = IDLE;
				end
			end
		endcase
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	// Enable low freezes the whole frame, divider included
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cur_q <= CUR_RESET;
		end else if (en_i) begin
			cur_q <= nxt_d;
		end
	end

	// ----------------------------------------------------------------
	// Link outputs
	// ----------------------------------------------------------------
	assign link.serial_clock       = cur_q.sck;
	assign link.master_data        = cur_q.tx[CHB_MSB];
	assign link.gain_port_select_n = cur_q.sel_n;
	assign link.preamp_shutdown    = cur_q.shdn;
	assign link.other_select_n     = cur_q.other_sel_n;
	assign link.converter_start    = cur_q.conv_start;

	// ----------------------------------------------------------------
	// Status outputs
	// ----------------------------------------------------------------
	assign busy_o                  = cur_q.busy;
	assign done_o                  = cur_q.done;
	assign echo_word_o             = cur_q.echo;

endmodule
`default_nettype wire

// ===== verilog/gain_amp.sv
// Amplifier end: shift register on the link clock, gain latched on deselect.
// Assumes the link clock idles low and only toggles while selected.
`timescale 1ns/1ps
`default_nettype none
module gain_amp
	import gain_port_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        en_i,
	gain_link_if.amp         link,
	output logic [3:0]       channel_a_gain_code_o,
	output logic [3:0]       channel_b_gain_code_o,
	output logic signed [7:0] gain_a_o,
	output logic signed [7:0] gain_b_o,
	output logic             shutdown_o
);

	typedef struct packed {
		logic [3:0] code_a;
		logic [3:0] code_b;
		gain_t      gain_a;
		gain_t      gain_b;
		logic       sel_s1;
		logic       sel_s2;
		logic       sel_s3;
		logic       shdn_s1;
		logic       shdn_s2;
	} sys_s;

	// Link-side state lives on three clock edges, so it cannot share one register
	logic [7:0] shift_q;
	logic [7:0] shift_d;
	logic       echo_q;
	logic [7:0] word_q;
	sys_s       sy_q;
	sys_s       sy_d;

	// ----------------------------------------------------------------
	// Link domain
	// ----------------------------------------------------------------
	always_comb begin
		shift_d = {shift_q[6:0], link.master_data};
	end

	always_ff @(posedge link.serial_clock or negedge rst_n_i) begin
		if (!rst_n_i) begin
			shift_q <= WORD_RESET;
		end else if (!link.gain_port_select_n) begin
			shift_q <= shift_d;
		end
	end

	// Held word's top bit leads each rise, so the echo is the previous word
	always_ff @(negedge link.serial_clock or negedge rst_n_i) begin
		if (!rst_n_i) begin
			echo_q <= 1'b0;
		end else if (!link.gain_port_select_n) begin
			echo_q <= shift_q[CHB_MSB];
		end
	end

	// Frame word captured on the select rising edge; stable until the next frame
	always_ff @(posedge link.gain_port_select_n or negedge rst_n_i) begin
		if (!rst_n_i) begin
			word_q <= WORD_RESET;
		end else begin
			word_q <= shift_q;
		end
	end

	assign link.gain_echo_out = echo_q;

	// ----------------------------------------------------------------
	// System domain: select level synchronised, word taken after rise
	// ----------------------------------------------------------------
	always_comb begin
		sy_d         = sy_q;
		sy_d.sel_s1  = link.gain_port_select_n;
		sy_d.sel_s2  = sy_q.sel_s1;
		sy_d.sel_s3  = sy_q.sel_s2;
		sy_d.shdn_s1 = link.preamp_shutdown;
		sy_d.shdn_s2 = sy_q.shdn_s1;
		if (sy_q.shdn_s2) begin
			sy_d.code_a = CODE_ZERO;
			sy_d.code_b = CODE_ZERO;
		end else if (sy_q.sel_s2 && !sy_q.sel_s3) begin
			sy_d.code_a = word_q[CHA_MSB:CHA_LSB];
			sy_d.code_b = word_q[CHB_MSB:CHB_LSB];
		end
		sy_d.gain_a = gain_of(sy_q.code_a);
		sy_d.gain_b = gain_of(sy_q.code_b);
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sy_q <= '{code_a: CODE_ZERO, code_b: CODE_ZERO,
				gain_a: 8'sh00, gain_b: 8'sh00, sel_s1: 1'b1, sel_s2: 1'b1,
				sel_s3: 1'b1, shdn_s1: 1'b0, shdn_s2: 1'b0};
		end else if (en_i) begin
			sy_q <= sy_d;
		end
	end

	assign channel_a_gain_code_o = sy_q.code_a;
	assign channel_b_gain_code_o = sy_q.code_b;
	assign gain_a_o              = sy_q.gain_a;
	assign gain_b_o              = sy_q.gain_b;
	assign shutdown_o            = sy_q.shdn_s2;

endmodule
`default_nettype wire

// ===== testbench/gain_link_checker.sv
// Assertions on the wires of the gain link.
// Assumes the bench instantiates it beside the link interface.
`timescale 1ns/1ps
`default_nettype none
module gain_link_checker (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic serial_clock,
	input  wire logic master_data,
	input  wire logic gain_port_select_n,
	input  wire logic gain_echo_out,
	input  wire logic other_select_n,
	input  wire logic converter_start
);
	// --------------------------------------------------------------
	// Rising-edge counter per frame
	// --------------------------------------------------------------
	logic       sck_q;
	logic [3:0] rise_q;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sck_q  <= 1'b0;
			rise_q <= 4'h0;
		end else begin
			sck_q  <= serial_clock;
			if (gain_port_select_n)
				rise_q <= 4'h0;
			else if (serial_clock && !sck_q)
				rise_q <= rise_q + 4'h1;
		end
	end
	// --------------------------------------------------------------
	// Properties
	// --------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	property p_idle_sck; gain_port_select_n |-> !serial_clock; endproperty
	property p_desel; other_select_n && !converter_start; endproperty
	property p_setup; $fell(gain_port_select_n) |-> !serial_clock [*3]; endproperty
	property p_high; $rose(serial_clock) |-> serial_clock [*3] ##1 !serial_clock; endproperty
	property p_data; serial_clock |-> $stable(master_data); endproperty
	property p_echo;
		$changed(gain_echo_out) && !gain_port_select_n && !$past(gain_port_select_n)
			|-> $fell(serial_clock);
	endproperty
	property p_bits; $rose(gain_port_select_n) |-> rise_q == 4'h8; endproperty
	property p_max; serial_clock && !sck_q |-> rise_q < 4'h8; endproperty
	property p_frame; $fell(gain_port_select_n) |-> ##[48:52] gain_port_select_n; endproperty
	a_idle_sck: assert property (p_idle_sck) else $error("link clock runs while deselected");
	a_desel: assert property (p_desel) else $error("other device selected");
	a_setup: assert property (p_setup) else $error("clock edge too soon after select");
	a_high: assert property (p_high) else $error("link clock high phase wrong");
	a_data: assert property (p_data) else $error("data moved while clock high");
	a_echo: assert property (p_echo) else $error("echo moved off falling edge");
	a_bits: assert property (p_bits) else $error("frame bit count wrong");
	a_max: assert property (p_max) else $error("clock edge after eighth bit");
	a_frame: assert property (p_frame) else $error("select not released in time");
	c_frame: cover property ($rose(gain_port_select_n));
	c_echo: cover property ($fell(serial_clock) && gain_echo_out);
	c_data: cover property ($rose(serial_clock) && master_data);
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
// Bench joining the gain-port master and amplifier over one link.
// Assumes the package, interface and both ends compile first.
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import gain_port_pkg::*;
;
	logic       clk_i, rst_n_i, start_i, shutdown_i, busy_o, done_o, shutdown_o;
	logic [3:0] ca_i, cb_i, code_a_o, code_b_o;
	logic [7:0] echo_word_o, gain_a_o, gain_b_o, cap_q, ecap_q;
	int         num_errors = 0;
	int         tests_run = 0;
	int         cyc = 0;
	gain_link_if link ();
	gain_master gain_master_i (.clk_i, .rst_n_i, .en_i(1'b1), .start_i,
		.channel_a_gain_code_i(ca_i), .channel_b_gain_code_i(cb_i), .shutdown_i,
		.busy_o, .done_o, .echo_word_o, .link(link));
	gain_amp gain_amp_i (.clk_i, .rst_n_i, .en_i(1'b1), .link(link),
		.channel_a_gain_code_o(code_a_o), .channel_b_gain_code_o(code_b_o),
		.gain_a_o, .gain_b_o, .shutdown_o);
	gain_link_checker gain_link_checker_i (.clk_i, .rst_n_i,
		.serial_clock(link.serial_clock), .master_data(link.master_data),
		.gain_port_select_n(link.gain_port_select_n), .gain_echo_out(link.gain_echo_out),
		.other_select_n(link.other_select_n), .converter_start(link.converter_start));
	// --------------------------------------------------------------
	// Clock, timeout and wire capture
	// --------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 4000) begin
			num_errors++;
			print_verdict();
		end
	end
	always @(posedge link.serial_clock) begin
		if (!link.gain_port_select_n) cap_q = {cap_q[6:0], link.master_data};
	end
	// Echo taken on the rising edge, half a period after it moved; the master samples it at the falling edge
	always @(posedge link.serial_clock) begin
		if (!link.gain_port_select_n) ecap_q = {ecap_q[6:0], link.gain_echo_out};
	end
	// --------------------------------------------------------------
	// Tasks
	// --------------------------------------------------------------
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	function automatic logic [7:0] exp_gain(input logic [3:0] c);
		logic [7:0] t [8];
		t = '{8'h00, 8'hff, 8'hfe, 8'hfb, 8'hf6, 8'hec, 8'hce, 8'h9c};
		return c[3] ? 8'h00 : t[c[2:0]];
	endfunction
	task automatic send(input logic [3:0] a, input logic [3:0] b);
		logic [7:0] prev;
		int         n;
		prev = {code_b_o, code_a_o};
		ca_i = a;
		cb_i = b;
		start_i = 1'b1;
		n = 0;
		while (done_o !== 1'b1 && n < 100) begin
			@(posedge clk_i);
			#1;
			n++;
			// Second start mid-frame must be ignored
			start_i = (n == 20);
			if (n == 20) begin
				ca_i = ~a;
				cb_i = ~b;
			end
			if (n == 25) check("held", {code_b_o, code_a_o}, prev);
			if (n == 25) check("busy", {7'h00, busy_o}, 8'h01);
		end
		check("done", {7'h00, done_o}, 8'h01);
		check("idle", {7'h00, busy_o}, 8'h00);
		repeat (8) @(posedge clk_i);
		#1;
		check("wire", cap_q, {b, a});
		check("echo_wire", ecap_q, prev);
		check("echo_word", echo_word_o, prev);
		check("code_a", {4'h0, code_a_o}, {4'h0, a});
		check("code_b", {4'h0, code_b_o}, {4'h0, b});
		check("gain_a", gain_a_o, exp_gain(a));
		check("gain_b", gain_b_o, exp_gain(b));
	endtask
	task automatic print_verdict();
		if (num_errors == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// --------------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------------
	initial begin
		rst_n_i = 1'b0;
		start_i = 1'b0;
		shutdown_i = 1'b0;
		ca_i = 4'h0;
		cb_i = 4'h0;
		repeat (5) @(posedge clk_i);
		#1;
		rst_n_i = 1'b1;
		check("reset_echo", echo_word_o, WORD_RESET);
		for (int i = 0; i < 16; i++) send(4'(i), 4'(15 - i));
		shutdown_i = 1'b1;
		repeat (10) @(posedge clk_i);
		#1;
		check("shutdown", {7'h00, shutdown_o}, 8'h01);
		check("shut_code", {4'h0, code_a_o}, 8'h00);
		print_verdict();
	end
endmodule
`default_nettype wire
